//--- logic/nvs_cfg.svh
// Purpose: constants for the host-side controller of a 32K x 8 nonvolatile static memory
// Assumes: 100 MHz clk_sys, period 10 ns
// Notes: timing counts derive from printed times; long counts are module parameters
`ifndef NVS_CFG_SVH
`define NVS_CFG_SVH

`define NVS_CLK_PERIOD_NS     10
`define NVS_ADDR_W            15
`define NVS_DATA_W            8
`define NVS_KEY_MASK          15'h3FFF
`define NVS_KEY_0             15'h0E38
`define NVS_KEY_1             15'h31C7
`define NVS_KEY_2             15'h03E0
`define NVS_KEY_3             15'h3C1F
`define NVS_KEY_4             15'h303F
`define NVS_KEY_SAVE          15'h0FC0
`define NVS_KEY_RESTORE       15'h0C63
// access and strobe timing in ns
`define NVS_ACCESS_NS         55
`define NVS_STROBE_NS         45
`define NVS_SETUP_NS          25
`define NVS_FLOAT_NS          20
`define NVS_IDLE_NS           20
// busy periods in us
`define NVS_SAVE_US           10000
`define NVS_RESTORE_US        20
`define NVS_POWERUP_US        550
`define NVS_CYC(ns)           (((ns) + `NVS_CLK_PERIOD_NS - 1) / `NVS_CLK_PERIOD_NS)
`define NVS_US_CYC(us)        (((us) * 1000) / `NVS_CLK_PERIOD_NS)

`endif

//--- logic/nvs_pkg.sv
// Purpose: types for the nonvolatile memory host controller
// Assumes: constants come from nvs_cfg.svh
// Notes: none
`include "nvs_cfg.svh"
package nvs_pkg;
    typedef enum logic [1:0] {
        NVS_OP_READ    = 2'h0,
        NVS_OP_WRITE   = 2'h1,
        NVS_OP_SAVE    = 2'h2,
        NVS_OP_RESTORE = 2'h3
    } nvs_op_t;

    typedef struct packed {
        nvs_op_t                    op;
        logic [`NVS_ADDR_W-1:0]     addr;
        logic [`NVS_DATA_W-1:0]     wdata;
    } nvs_req_t;

    typedef struct packed {
        logic                       sel_n;
        logic                       oe_n;
        logic                       we_n;
        logic [`NVS_ADDR_W-1:0]     byte_address;
    } nvs_pins_t;

    typedef enum logic [2:0] {
        NVS_ST_IDLE   = 3'h0,
        NVS_ST_SETUP  = 3'h1,
        NVS_ST_STROBE = 3'h3,
        NVS_ST_END    = 3'h2,
        NVS_ST_GAP    = 3'h6,
        NVS_ST_BUSY   = 3'h7,
        NVS_ST_PWRUP  = 3'h5
    } nvs_state_t;
endpackage : nvs_pkg

//--- logic/nvs_timer.sv
// Purpose: down counter for strobe, gap and busy intervals
// Assumes: load wins over counting
// Notes: done is high while the count stands at zero
`timescale 1ns/1ps
`default_nettype none
module nvs_timer #(
    parameter int W = 24
) (
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    input  wire logic         clk_en,
    // control
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    output var  logic         done
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;

    always_comb begin
        cnt_d = cnt_q;
        if (load) begin
            cnt_d = load_val;
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (clk_en) begin
            cnt_q <= cnt_d;
        end
    end

    assign done = (cnt_q == '0);
endmodule : nvs_timer
`default_nettype wire

//--- logic/nvs_host.sv
// Purpose: host controller driving a 32K x 8 nonvolatile static memory over its pins
// Assumes: pin inputs synchronous to clk_sys; supply state given as digital flags
// Notes: save and restore are issued as the six-read key sequence, select-controlled
`timescale 1ns/1ps
`default_nettype none
`include "nvs_cfg.svh"
module nvs_host
    import nvs_pkg::*;
#(
    parameter int SAVE_CYC    = `NVS_US_CYC(`NVS_SAVE_US),
    parameter int RESTORE_CYC = `NVS_US_CYC(`NVS_RESTORE_US),
    parameter int PWRUP_CYC   = `NVS_US_CYC(`NVS_POWERUP_US)
) (
    // clock and reset
    input  wire logic                   clk_sys,
    input  wire logic                   rst_n,
    input  wire logic                   clk_en,
    // user request
    input  wire logic                   req_valid,
    input  wire nvs_req_t               req,
    output var  logic                   req_ready,
    output var  logic                   rsp_valid,
    output var  logic [`NVS_DATA_W-1:0] rsp_rdata,
    output var  logic                   save_refused,
    // supply flags
    input  wire logic                   supply_low,
    input  wire logic                   power_good,
    // memory pins
    output var  nvs_pins_t              pins,
    input  wire logic [`NVS_DATA_W-1:0] data_bus_i,
    output var  logic [`NVS_DATA_W-1:0] data_bus_o,
    output var  logic                   data_bus_oe
);
    localparam int TW        = 24;
    localparam int ACC_CYC   = `NVS_CYC(`NVS_ACCESS_NS);
    localparam int STR_CYC   = `NVS_CYC(`NVS_STROBE_NS);
    localparam int SETUP_CYC = `NVS_CYC(`NVS_SETUP_NS);
    localparam int GAP_CYC   = `NVS_CYC(`NVS_IDLE_NS);

    function automatic logic [`NVS_ADDR_W-1:0] key_addr(input logic [2:0] idx,
                                                        input logic       rest);
        logic [`NVS_ADDR_W-1:0] a;
        a = `NVS_KEY_0;
        case (idx)
            3'h0: a = `NVS_KEY_0;
            3'h1: a = `NVS_KEY_1;
            3'h2: a = `NVS_KEY_2;
            3'h3: a = `NVS_KEY_3;
            3'h4: a = `NVS_KEY_4;
            default: a = rest ? `NVS_KEY_RESTORE : `NVS_KEY_SAVE;
        endcase
        return a & `NVS_KEY_MASK;
    endfunction : key_addr

    function automatic logic [TW-1:0] cyc(input int n);
        return (n < 1) ? TW'(1) : TW'(n);
    endfunction : cyc

    nvs_state_t             st_q,   st_d;
    nvs_op_t                op_q,   op_d;
    logic [`NVS_ADDR_W-1:0] addr_q, addr_d;
    logic [`NVS_DATA_W-1:0] wd_q,   wd_d;
    logic [2:0]             step_q, step_d;
    logic                   pwr_q,  pwr_d;
    nvs_pins_t              pins_q, pins_d;
    logic                   oe_q,   oe_d;
    logic                   rdy_q,  rdy_d;
    logic                   rv_q,   rv_d;
    logic [`NVS_DATA_W-1:0] rd_q,   rd_d;
    logic                   ref_q,  ref_d;
    logic                   t_load;
    logic [TW-1:0]          t_val;
    logic                   t_done;

    nvs_timer #(.W(TW)) u_timer (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .clk_en   (clk_en),
        .load     (t_load),
        .load_val (t_val),
        .done     (t_done)
    );

    always_comb begin
        st_d   = st_q;
        op_d   = op_q;
        addr_d = addr_q;
        wd_d   = wd_q;
        step_d = step_q;
        pwr_d  = pwr_q;
        pins_d = pins_q;
        oe_d   = 1'b0;
        rdy_d  = 1'b0;
        rv_d   = 1'b0;
        rd_d   = rd_q;
        ref_d  = 1'b0;
        t_load = 1'b0;
        t_val  = '0;
        // a supply dip means the device will restore on its own again
        if (!power_good) begin
            pwr_d = 1'b1;
        end
        case (st_q)
            NVS_ST_IDLE: begin
                pins_d.sel_n = 1'b1;
                pins_d.we_n  = 1'b1;
                pins_d.oe_n  = 1'b1;
                if (pwr_q || !power_good) begin
                    st_d = NVS_ST_PWRUP;
                end else if (req_valid && rdy_q) begin
                    op_d   = req.op;
                    wd_d   = req.wdata;
                    step_d = 3'h0;
                    if (req.op == NVS_OP_SAVE && supply_low) begin
                        ref_d = 1'b1;
                        rdy_d = 1'b1;
                    end else begin
                        addr_d = (req.op == NVS_OP_READ || req.op == NVS_OP_WRITE) ?
                                 req.addr : key_addr(3'h0, 1'b0);
                        pins_d.byte_address = addr_d;
                        st_d   = NVS_ST_SETUP;
                        t_load = 1'b1;
                        t_val  = cyc(SETUP_CYC);
                    end
                end else begin
                    rdy_d = 1'b1;
                end
            end
            NVS_ST_SETUP: begin
                // address settles before any strobe falls
                if (t_done) begin
                    st_d         = NVS_ST_STROBE;
                    pins_d.sel_n = 1'b0;
                    t_load       = 1'b1;
                    if (op_q == NVS_OP_WRITE) begin
                        pins_d.we_n = 1'b0;
                        pins_d.oe_n = 1'b1;
                        oe_d        = 1'b1;
                        t_val       = cyc(STR_CYC);
                    end else begin
                        pins_d.we_n = 1'b1;
                        pins_d.oe_n = (op_q != NVS_OP_READ);
                        t_val       = cyc(ACC_CYC);
                    end
                end
            end
            NVS_ST_STROBE: begin
                oe_d = (op_q == NVS_OP_WRITE);
                if (t_done) begin
                    // address held until the strobe ends the access
                    st_d         = NVS_ST_END;
                    pins_d.sel_n = 1'b1;
                    pins_d.we_n  = 1'b1;
                    pins_d.oe_n  = 1'b1;
                    if (op_q == NVS_OP_READ) begin
                        rd_d = data_bus_i;
                        rv_d = 1'b1;
                    end
                end
            end
            NVS_ST_END: begin
                // keep drivers on one extra cycle for data hold
                oe_d   = (op_q == NVS_OP_WRITE);
                st_d   = NVS_ST_GAP;
                t_load = 1'b1;
                t_val  = cyc(GAP_CYC);
            end
            NVS_ST_GAP: begin
                if (t_done) begin
                    if ((op_q == NVS_OP_SAVE || op_q == NVS_OP_RESTORE) && step_q != 3'h5) begin
                        // next key read; no other access may slip in between
                        step_d              = step_q + 3'h1;
                        addr_d              = key_addr(step_d, op_q == NVS_OP_RESTORE);
                        pins_d.byte_address = addr_d;
                        st_d                = NVS_ST_SETUP;
                        t_load              = 1'b1;
                        t_val               = cyc(SETUP_CYC);
                    end else if (op_q == NVS_OP_SAVE || op_q == NVS_OP_RESTORE) begin
                        // device is deaf during erase/program or clear/reload
                        st_d   = NVS_ST_BUSY;
                        t_load = 1'b1;
                        t_val  = (op_q == NVS_OP_SAVE) ? cyc(SAVE_CYC) : cyc(RESTORE_CYC);
                    end else begin
                        st_d  = NVS_ST_IDLE;
                        rdy_d = 1'b1;
                    end
                end
            end
            NVS_ST_BUSY: begin
                if (t_done) begin
                    st_d  = NVS_ST_IDLE;
                    rv_d  = 1'b1;
                    rdy_d = 1'b1;
                end
            end
            NVS_ST_PWRUP: begin
                // timer restarts while supply is still absent
                pins_d.sel_n = 1'b1;
                pins_d.we_n  = 1'b1;
                pins_d.oe_n  = 1'b1;
                if (!power_good) begin
                    t_load = 1'b1;
                    t_val  = cyc(PWRUP_CYC);
                end else if (t_done) begin
                    pwr_d = 1'b0;
                    st_d  = NVS_ST_IDLE;
                    rdy_d = 1'b1;
                end
            end
            default: begin
                st_d = NVS_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_q   <= NVS_ST_IDLE;
            op_q   <= NVS_OP_READ;
            addr_q <= '0;
            wd_q   <= '0;
            step_q <= 3'h0;
            pwr_q  <= 1'b1;
            pins_q <= '{sel_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, byte_address: '0};
            oe_q   <= 1'b0;
            rdy_q  <= 1'b0;
            rv_q   <= 1'b0;
            rd_q   <= '0;
            ref_q  <= 1'b0;
        end else if (clk_en) begin
            st_q   <= st_d;
            op_q   <= op_d;
            addr_q <= addr_d;
            wd_q   <= wd_d;
            step_q <= step_d;
            pwr_q  <= pwr_d;
            pins_q <= pins_d;
            oe_q   <= oe_d;
            rdy_q  <= rdy_d;
            rv_q   <= rv_d;
            rd_q   <= rd_d;
            ref_q  <= ref_d;
        end
    end

    // write data registered once at request, so it is already a flop
    assign pins         = pins_q;
    assign data_bus_o   = wd_q;
    assign data_bus_oe  = oe_q;
    assign req_ready    = rdy_q;
    assign rsp_valid    = rv_q;
    assign rsp_rdata    = rd_q;
    assign save_refused = ref_q;
endmodule : nvs_host
`default_nettype wire

//--- test/nvs_host_monitor.sv
// Purpose: pin and handshake checks for nvs_host
// Assumes: one clock domain, ports only
// Notes: bound from the bench top file
`timescale 1ns/1ps
`default_nettype none
`include "nvs_cfg.svh"
module nvs_host_monitor
    import nvs_pkg::*;
(
    // clock and reset
    input wire logic                   clk_sys,
    input wire logic                   rst_n,
    input wire logic                   clk_en,
    // user side
    input wire logic                   req_valid,
    input wire nvs_req_t               req,
    input wire logic                   req_ready,
    input wire logic                   rsp_valid,
    input wire logic [`NVS_DATA_W-1:0] rsp_rdata,
    input wire logic                   save_refused,
    input wire logic                   supply_low,
    input wire logic                   power_good,
    // memory pins
    input wire nvs_pins_t              pins,
    input wire logic [`NVS_DATA_W-1:0] data_bus_i,
    input wire logic [`NVS_DATA_W-1:0] data_bus_o,
    input wire logic                   data_bus_oe
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    wire take = req_valid && req_ready;

    wr_oe_a: assert property (!pins.we_n |-> pins.oe_n && data_bus_oe)
        else $error("write without bus drive or with output enable low");
    sel_addr_a: assert property ((!pins.sel_n)[*2] |-> $stable(pins.byte_address))
        else $error("address moved while selected");
    sel_width_a: assert property ($fell(pins.sel_n) |-> (!pins.sel_n)[*5])
        else $error("select pulse too short");
    sel_gap_a: assert property ($rose(pins.sel_n) |=> pins.sel_n)
        else $error("select not toggled between accesses");
    // a refused save keeps ready up, so the handshake stays open for the next request
    take_drop_a: assert property (take && !(req.op == NVS_OP_SAVE && supply_low) |=> !req_ready)
        else $error("ready stayed high after take");
    rd_rsp_a: assert property (take && req.op == NVS_OP_READ |-> ##[8:12] rsp_valid)
        else $error("read answer missing");
    refuse_a: assert property (take && req.op == NVS_OP_SAVE && supply_low |=> save_refused && req_ready)
        else $error("save on low supply not refused");
    pwr_quiet_a: assert property ((!power_good)[*2] |-> !req_ready && pins.we_n)
        else $error("activity during power-up restore");

    cover property (take && req.op == NVS_OP_READ ##[8:12] rsp_valid);
    cover property (save_refused);
    cover property (!pins.sel_n && !pins.we_n);
endmodule : nvs_host_monitor
`default_nettype wire

//--- test/nvs_mem_model.sv
// Purpose: behavioural 32K x 8 memory with nonvolatile shadow
// Assumes: host pins registered on clk_sys
// Notes: busy periods counted on clk_sys; no access delay modelled
`timescale 1ns/1ps
`default_nettype none
`include "nvs_cfg.svh"
module nvs_mem_model
    import nvs_pkg::*;
#(
    parameter int SAVE_T = 40,
    parameter int REST_T = 15,
    parameter int PUP_T  = 25
) (
    // clock
    input  wire logic       clk_sys,
    // host pins
    input  wire nvs_pins_t  pins,
    input  wire logic [7:0] data_bus_o,
    input  wire logic       data_bus_oe,
    output var  logic [7:0] data_bus_i,
    // supply flags
    input  wire logic       supply_low,
    input  wire logic       power_good
);
    logic [7:0]  sram [32768];
    logic [7:0]  nv   [32768];
    logic [14:0] keys [5];
    logic [14:0] wa;
    logic [7:0]  last;
    logic        rd_cyc;
    int          busy_n;
    int          step;
    wire         drv   = !pins.sel_n && !pins.oe_n && pins.we_n && busy_n == 0;
    wire         wr_on = !pins.sel_n && !pins.we_n && busy_n == 0;
    wire [7:0]   val   = data_bus_oe ? data_bus_o : sram[pins.byte_address];
    // undriven bus shows inverted last value, never a lucky match
    assign data_bus_i = (drv || data_bus_oe) ? val : ~last;

    task automatic restore(input int t);
        for (int i = 0; i < 32768; i++)
            sram[i] = 8'h00;
        sram = nv;
        busy_n = t;
    endtask : restore

    initial begin
        keys = '{`NVS_KEY_0, `NVS_KEY_1, `NVS_KEY_2, `NVS_KEY_3, `NVS_KEY_4};
        for (int i = 0; i < 32768; i++) begin
            nv[i] = 8'(i) ^ 8'h5A;
            sram[i] = ~nv[i];
        end
        busy_n = 0;
        step = 0;
        last = 8'h00;
    end
    always @(posedge clk_sys) if (busy_n > 0) busy_n = busy_n - 1;
    always @* if (drv || data_bus_oe) last = val;
    always @(posedge wr_on) wa = pins.byte_address;
    // we_n rises with sel_n at a write end, so remember the kind of access at its start
    always @(negedge pins.sel_n) rd_cyc = pins.we_n;
    always @(negedge wr_on) begin
        sram[wa] = data_bus_o;
        step = 0;
    end
    always @(posedge pins.sel_n) begin
        logic [14:0] k;
        k = pins.byte_address & `NVS_KEY_MASK;
        if (busy_n == 0 && rd_cyc === 1'b1 && pins.we_n === 1'b1) begin
            if (step == 5 && k == `NVS_KEY_SAVE) begin
                if (!supply_low) begin
                    nv = sram;
                    busy_n = SAVE_T;
                end
                step = 0;
            end else if (step == 5 && k == `NVS_KEY_RESTORE) begin
                restore(REST_T);
                step = 0;
            end else if (step < 5 && k == keys[step])
                step = step + 1;
            else
                step = (k == `NVS_KEY_0) ? 1 : 0;
        end
    end
    always @(negedge power_good) step = 0;
    always @(posedge power_good) restore(PUP_T);
endmodule : nvs_mem_model
`default_nettype wire

//--- test/nvs_host_tb.sv
// Purpose: self-checking bench for nvs_host against a memory model
// Assumes: shortened busy counts
// Notes: inputs change 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
module nvs_host_tb
    import nvs_pkg::*;
;
    logic       clk_sys;
    logic       rst_n;
    logic       req_valid;
    nvs_req_t   req;
    logic       req_ready;
    logic       rsp_valid;
    logic [7:0] rsp_rdata;
    logic       save_refused;
    logic       supply_low;
    logic       power_good;
    nvs_pins_t  pins;
    logic [7:0] data_bus_i;
    logic [7:0] data_bus_o;
    logic       data_bus_oe;
    int         err_count;
    int         comparisons;

    nvs_host #(.SAVE_CYC(50), .RESTORE_CYC(20), .PWRUP_CYC(30)) i_dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(1'b1), .req_valid(req_valid),
        .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .save_refused(save_refused), .supply_low(supply_low), .power_good(power_good),
        .pins(pins), .data_bus_i(data_bus_i), .data_bus_o(data_bus_o),
        .data_bus_oe(data_bus_oe));
    nvs_mem_model i_mem (
        .clk_sys(clk_sys), .pins(pins), .data_bus_o(data_bus_o), .data_bus_oe(data_bus_oe),
        .data_bus_i(data_bus_i), .supply_low(supply_low), .power_good(power_good));

    always #5 clk_sys = ~clk_sys;

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask : chk

    // w 0 waits for ready, 1 for the answer pulse
    task automatic wait_hi(input int w);
        int n;
        n = 0;
        while ((w == 0 ? req_ready : rsp_valid) !== 1'b1 && n < 3000) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        chk(8'(n == 3000), 8'h00);
    endtask : wait_hi

    task automatic op(input nvs_op_t o, input logic [14:0] a, input logic [7:0] d);
        wait_hi(0);
        req = '{op: o, addr: a, wdata: d};
        req_valid = 1'b1;
        @(posedge clk_sys);
        #1;
        req_valid = 1'b0;
        if (o != NVS_OP_WRITE && !(o == NVS_OP_SAVE && supply_low))
            wait_hi(1);
    endtask : op

    task automatic rd(input logic [14:0] a, input logic [7:0] exp);
        op(NVS_OP_READ, a, 8'h00);
        chk(rsp_rdata, exp);
    endtask : rd

    task automatic t_pwrup();
        repeat (10) @(posedge clk_sys);
        #1;
        chk({7'h00, req_ready}, 8'h00);
        power_good = 1'b1;
        rd(15'h0005, 8'h5F);
        $display("test pwrup done");
    endtask : t_pwrup

    task automatic t_rw();
        logic [14:0] a [4] = '{15'h0000, 15'h7FFF, 15'h4123, 15'h0123};
        for (int i = 0; i < 4; i++)
            op(NVS_OP_WRITE, a[i], 8'hA0 + 8'(i));
        for (int i = 0; i < 4; i++)
            rd(a[i], 8'hA0 + 8'(i));
        $display("test rw done");
    endtask : t_rw

    task automatic t_key();
        op(NVS_OP_WRITE, 15'h0200, 8'hC3);
        op(NVS_OP_SAVE, 15'h0000, 8'h00);
        op(NVS_OP_WRITE, 15'h0200, 8'h3C);
        rd(15'h0200, 8'h3C);
        op(NVS_OP_RESTORE, 15'h0000, 8'h00);
        rd(15'h0200, 8'hC3);
        op(NVS_OP_RESTORE, 15'h0000, 8'h00);
        rd(15'h0200, 8'hC3);
        $display("test key done");
    endtask : t_key

    task automatic t_refuse();
        supply_low = 1'b1;
        op(NVS_OP_WRITE, 15'h0200, 8'h77);
        op(NVS_OP_SAVE, 15'h0000, 8'h00);
        chk({7'h00, save_refused}, 8'h01);
        // ready stays up after a refusal; let an edge pass before the next request
        @(posedge clk_sys);
        #1;
        supply_low = 1'b0;
        op(NVS_OP_RESTORE, 15'h0000, 8'h00);
        rd(15'h0200, 8'hC3);
        $display("test refuse done");
    endtask : t_refuse

    task automatic t_dip();
        op(NVS_OP_WRITE, 15'h0200, 8'h11);
        wait_hi(0);
        power_good = 1'b0;
        repeat (5) @(posedge clk_sys);
        #1;
        power_good = 1'b1;
        rd(15'h0200, 8'hC3);
        $display("test dip done");
    endtask : t_dip

    task automatic summarize();
        $display("comparisons=%0d err_count=%0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : summarize

    initial begin
        clk_sys = 1'b0;
        rst_n = 1'b0;
        req_valid = 1'b0;
        req = '0;
        supply_low = 1'b0;
        power_good = 1'b0;
        err_count = 0;
        comparisons = 0;
        repeat (10) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        t_pwrup();
        t_rw();
        t_key();
        t_refuse();
        t_dip();
        summarize();
    end

    // tests need about 900 cycles
    initial begin
        #200000;
        err_count++;
        summarize();
    end
endmodule : nvs_host_tb

bind nvs_host nvs_host_monitor i_mon (
    .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .save_refused(save_refused), .supply_low(supply_low), .power_good(power_good),
    .pins(pins), .data_bus_i(data_bus_i), .data_bus_o(data_bus_o), .data_bus_oe(data_bus_oe));
`default_nettype wire
